// File: frw_defs.svh
// Constants shared by both ends of the serial flash command link.
// Assumes a 10 MHz system clock at both ends and a link clock well below it.
`ifndef FRW_DEFS_SVH
`define FRW_DEFS_SVH

// Opcodes
`define FRW_OP_WR_EN 8'h06
`define FRW_OP_WR_DIS 8'h04
`define FRW_OP_RESUME 8'h7A
`define FRW_OP_HALT 8'h75
`define FRW_OP_WR_STAT 8'h01
`define FRW_OP_PROGRAM 8'h02
`define FRW_OP_ERASE 8'h20
`define FRW_OP_RD_STAT 8'h05
`define FRW_OP_RD_STAT2 8'h35

// Status byte bit positions
`define FRW_ST_BUSY 0
`define FRW_ST_LATCH 1
`define FRW_ST_HALTED 2

// Protection field positions and reset value
`define FRW_PB_CODE_HI 2
`define FRW_PB_TOPBOT 3
`define FRW_PB_GRAN 4
`define FRW_PB_COMPL 5
`define FRW_PB_RESET 6'h00
`define FRW_ARRAY_TOP 22'h200000

// Timing
`define FRW_CLK_NS 100
`define FRW_RESUME_NS 5000
`define FRW_RESUME_CYC (`FRW_RESUME_NS / `FRW_CLK_NS)
`define FRW_PROG_NS 8000
`define FRW_PROG_CYC (`FRW_PROG_NS / `FRW_CLK_NS)
`define FRW_ERASE_NS 40000
`define FRW_ERASE_CYC (`FRW_ERASE_NS / `FRW_CLK_NS)
`define FRW_SCK_NS 800
`define FRW_SCK_HALF_CYC (`FRW_SCK_NS / (2 * `FRW_CLK_NS))
`define FRW_CS_GAP_CYC 16

// Host register offsets and fields
`define FRW_REG_CTRL 8'h00
`define FRW_REG_TXDATA 8'h04
`define FRW_REG_STATUS 8'h08
`define FRW_REG_RXDATA 8'h0C
`define FRW_CTRL_NBITS_LSB 8
`define FRW_MAX_BITS 6'h28

`endif

// File: frw_pkg.sv
// Types shared by both ends of the flash command link.
// Assumes nothing of its surroundings.
package frw_pkg;
	typedef enum logic [1:0] {
		FRW_RUN_NONE = 2'b00,
		FRW_RUN_PROG = 2'b01,
		FRW_RUN_ERASE = 2'b10
	} frw_run_e;

	typedef enum logic [2:0] {
		FRW_H_IDLE = 3'b000,
		FRW_H_LEAD = 3'b001,
		FRW_H_LOW = 3'b010,
		FRW_H_HIGH = 3'b011,
		FRW_H_TRAIL = 3'b100,
		FRW_H_GAP = 3'b101
	} frw_host_e;
endpackage

// File: frw_if.sv
// Serial link between flash host controller and flash command logic.
// Assumes both ends sample the other's outputs through their own synchronisers.
interface frw_if;
	logic cs_n;
	logic sclk;
	logic mosi;
	logic miso;

	modport dev (
		input cs_n,
		input sclk,
		input mosi,
		output miso
	);

	modport host (
		output cs_n,
		output sclk,
		output mosi,
		input miso
	);
endinterface

// File: frw_device.sv
// Flash command logic: resume, write enable latch, protection decode.
// Assumes link pins arrive from another clock domain and are synchronised here.
//
// Added by the designer: the register offsets and the strobed register port.
`include "frw_defs.svh"

module frw_device
	import frw_pkg::*;
(
	input wire logic mclk_i,
	input wire logic reset_n_i,
	frw_if.dev lnk,
	input wire logic wp_n_i,
	output logic busy_o,
	output logic suspended_o,
	output logic write_enable_latch_o,
	output logic [5:0] prot_bits_o
);

	function automatic logic frw_hit(input logic [5:0] pb, input logic [23:0] addr);
		logic [21:0] size;
		logic [21:0] a;
		logic hit;
		size = 22'h000000;
		a = {1'b0, addr[20:0]};
		case (pb[`FRW_PB_CODE_HI:0])
			3'b000: size = 22'h000000;
			3'b001: size = pb[`FRW_PB_GRAN] ? 22'h001000 : 22'h010000;
			3'b010: size = pb[`FRW_PB_GRAN] ? 22'h002000 : 22'h020000;
			3'b011: size = pb[`FRW_PB_GRAN] ? 22'h004000 : 22'h040000;
			3'b100: size = pb[`FRW_PB_GRAN] ? 22'h008000 : 22'h080000;
			3'b101: size = pb[`FRW_PB_GRAN] ? 22'h008000 : 22'h100000;
			default: size = `FRW_ARRAY_TOP;
		endcase
		if (pb[`FRW_PB_TOPBOT]) begin
			hit = a < size;
		end else begin
			hit = a >= (`FRW_ARRAY_TOP - size);
		end
		return hit ^ pb[`FRW_PB_COMPL];
	endfunction

	logic [1:0] cs_s_q;
	logic [1:0] sck_s_q;
	logic [1:0] mosi_s_q;
	logic [1:0] wp_s_q;
	logic cs_prev_q;
	logic sck_prev_q;
	logic [2:0] bit_mod_q;
	logic [2:0] nbytes_q;
	logic [7:0] sh_q;
	logic [7:0] op_q;
	logic [7:0] wsr_data_q;
	logic [23:0] addr_q;
	logic [7:0] out_q;
	logic write_enable_latch_q;
	logic [5:0] pb_q;
	frw_run_e run_q;
	logic [15:0] timer_q;
	logic [15:0] prog_rem_q;
	logic [15:0] erase_rem_q;
	logic [15:0] res_cnt_q;
	logic prog_halt_q;
	logic erase_halt_q;

	logic sck_rise;
	logic frame_end;
	logic byte_done;
	logic [7:0] new_byte;
	logic whole;
	logic busy;
	logic halted;
	logic do_wr_en;
	logic do_wr_dis;
	logic do_resume;
	logic do_halt;
	logic do_wr_stat;
	logic do_prog;
	logic do_erase;
	logic op_done;
	logic [7:0] stat_byte;

	// Two flops at every pin before any logic
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cs_s_q <= 2'h3;
			sck_s_q <= 2'h0;
			mosi_s_q <= 2'h0;
			wp_s_q <= 2'h0;
			cs_prev_q <= 1'b1;
			sck_prev_q <= 1'b0;
		end else begin
			cs_s_q <= {cs_s_q[0], lnk.cs_n};
			sck_s_q <= {sck_s_q[0], lnk.sclk};
			mosi_s_q <= {mosi_s_q[0], lnk.mosi};
			wp_s_q <= {wp_s_q[0], wp_n_i};
			cs_prev_q <= cs_s_q[1];
			sck_prev_q <= sck_s_q[1];
		end
	end

	assign sck_rise = sck_s_q[1] & ~sck_prev_q & ~cs_s_q[1];
	assign frame_end = cs_s_q[1] & ~cs_prev_q;
	assign byte_done = sck_rise && (bit_mod_q == 3'h7);
	assign new_byte = {sh_q[6:0], mosi_s_q[1]};
	assign whole = (bit_mod_q == 3'h0) && (nbytes_q != 3'h0);

	// Frame shifter; counters clear whenever select is high
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			bit_mod_q <= 3'h0;
			nbytes_q <= 3'h0;
			sh_q <= 8'h00;
			op_q <= 8'h00;
			wsr_data_q <= 8'h00;
			addr_q <= 24'h000000;
		end else if (cs_s_q[1]) begin
			bit_mod_q <= 3'h0;
			nbytes_q <= 3'h0;
		end else if (sck_rise) begin
			sh_q <= new_byte;
			bit_mod_q <= bit_mod_q + 3'h1;
			if (byte_done) begin
				if (nbytes_q != 3'h7) begin
					nbytes_q <= nbytes_q + 3'h1;
				end
				case (nbytes_q)
					3'h0: op_q <= new_byte;
					3'h1: begin
						wsr_data_q <= new_byte;
						addr_q <= {addr_q[15:0], new_byte};
					end
					3'h2, 3'h3: addr_q <= {addr_q[15:0], new_byte};
					default: ; // Data beyond the address is not stored
				endcase
			end
		end
	end

	assign busy = (run_q != FRW_RUN_NONE);
	assign halted = prog_halt_q | erase_halt_q;
	assign stat_byte = {5'h00, halted, write_enable_latch_q, busy};

	// Only the opcode byte matters for the latch and resume commands
	assign do_wr_en = frame_end && whole && (op_q == `FRW_OP_WR_EN);
	assign do_wr_dis = frame_end && whole && (op_q == `FRW_OP_WR_DIS);
	assign do_resume = frame_end && whole && (op_q == `FRW_OP_RESUME) && halted && !busy;
	assign do_halt = frame_end && whole && (op_q == `FRW_OP_HALT) && busy && (res_cnt_q == 16'h0000)
		&& !(run_q == FRW_RUN_PROG && erase_halt_q);
	assign do_wr_stat = frame_end && whole && (op_q == `FRW_OP_WR_STAT) && (nbytes_q >= 3'h2)
		&& write_enable_latch_q && !busy && !halted && wp_s_q[1];
	assign do_prog = frame_end && whole && (op_q == `FRW_OP_PROGRAM) && (nbytes_q >= 3'h5)
		&& write_enable_latch_q && !busy && !prog_halt_q && !frw_hit(pb_q, addr_q);
	assign do_erase = frame_end && whole && (op_q == `FRW_OP_ERASE) && (nbytes_q >= 3'h4)
		&& write_enable_latch_q && !busy && !halted && !frw_hit(pb_q, addr_q);
	assign op_done = busy && (res_cnt_q == 16'h0000) && (timer_q <= 16'h0001) && !do_halt;

	// Set wins over any clear landing in the same cycle
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			write_enable_latch_q <= 1'b0;
		end else if (do_wr_en) begin
			write_enable_latch_q <= 1'b1;
		end else if (do_wr_dis || do_wr_stat || op_done) begin
			write_enable_latch_q <= 1'b0;
		end
	end

	// Protection bits survive only until reset in this model
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pb_q <= `FRW_PB_RESET;
		end else if (do_wr_stat) begin
			pb_q <= wsr_data_q[5:0];
		end
	end

	// Operation engine: run, halt, resume and countdown
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			run_q <= FRW_RUN_NONE;
			timer_q <= 16'h0000;
			prog_rem_q <= 16'h0000;
			erase_rem_q <= 16'h0000;
			res_cnt_q <= 16'h0000;
			prog_halt_q <= 1'b0;
			erase_halt_q <= 1'b0;
		end else if (do_resume) begin
			res_cnt_q <= 16'(`FRW_RESUME_CYC);
			if (prog_halt_q) begin
				run_q <= FRW_RUN_PROG;
				timer_q <= prog_rem_q;
				prog_halt_q <= 1'b0;
			end else begin
				run_q <= FRW_RUN_ERASE;
				timer_q <= erase_rem_q;
				erase_halt_q <= 1'b0;
			end
		end else if (do_halt) begin
			run_q <= FRW_RUN_NONE;
			if (run_q == FRW_RUN_PROG) begin
				prog_halt_q <= 1'b1;
				prog_rem_q <= timer_q;
			end else begin
				erase_halt_q <= 1'b1;
				erase_rem_q <= timer_q;
			end
		end else if (do_prog) begin
			run_q <= FRW_RUN_PROG;
			timer_q <= 16'(`FRW_PROG_CYC);
		end else if (do_erase) begin
			run_q <= FRW_RUN_ERASE;
			timer_q <= 16'(`FRW_ERASE_CYC);
		end else if (busy) begin
			// Work stands still until the restart latency has run out
			if (res_cnt_q != 16'h0000) begin
				res_cnt_q <= res_cnt_q - 16'h0001;
			end else if (timer_q > 16'h0001) begin
				timer_q <= timer_q - 16'h0001;
			end else begin
				run_q <= FRW_RUN_NONE;
			end
		end
	end

	// Status read-out; byte repeats for as long as the host clocks
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			out_q <= 8'h00;
		end else if (cs_s_q[1]) begin
			out_q <= 8'h00;
		end else if (byte_done && nbytes_q == 3'h0) begin
			if (new_byte == `FRW_OP_RD_STAT) begin
				out_q <= stat_byte;
			end else if (new_byte == `FRW_OP_RD_STAT2) begin
				out_q <= {2'h0, pb_q};
			end else begin
				out_q <= 8'h00;
			end
		end else if (sck_rise && nbytes_q != 3'h0) begin
			out_q <= {out_q[6:0], out_q[7]};
		end
	end

	assign lnk.miso = out_q[7];

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			busy_o <= 1'b0;
			suspended_o <= 1'b0;
			write_enable_latch_o <= 1'b0;
			prot_bits_o <= `FRW_PB_RESET;
		end else begin
			busy_o <= busy;
			suspended_o <= halted;
			write_enable_latch_o <= write_enable_latch_q;
			prot_bits_o <= pb_q;
		end
	end

endmodule

// File: frw_host.sv
// Host controller that frames commands onto the flash link.
// Assumes software drives the plain register port synchronous to mclk_i.
`include "frw_defs.svh"

module frw_host
	import frw_pkg::*;
(
	input wire logic mclk_i,
	input wire logic reset_n_i,
	frw_if.host lnk,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic we_i,
	input wire logic re_i,
	output logic [31:0] rdata_o
);

	frw_host_e st_q;
	logic [7:0] cnt_q;
	logic [39:0] shift_q;
	logic [31:0] tx_q;
	logic [5:0] bits_left_q;
	logic [7:0] rx_q;
	logic [1:0] miso_s_q;
	logic cs_n_q;
	logic sclk_q;
	logic mosi_q;
	logic start;
	logic phase_end;

	assign start = we_i && (addr_i == `FRW_REG_CTRL) && (st_q == FRW_H_IDLE)
		&& (wdata_i[13:8] != 6'h00) && (wdata_i[13:8] <= `FRW_MAX_BITS);
	assign phase_end = (cnt_q == 8'h00);

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			miso_s_q <= 2'h0;
		end else begin
			miso_s_q <= {miso_s_q[0], lnk.miso};
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tx_q <= 32'h00000000;
		end else if (we_i && addr_i == `FRW_REG_TXDATA) begin
			tx_q <= wdata_i;
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_o <= 32'h00000000;
		end else if (re_i) begin
			case (addr_i)
				`FRW_REG_CTRL: rdata_o <= 32'h00000000;
				`FRW_REG_TXDATA: rdata_o <= tx_q;
				`FRW_REG_STATUS: rdata_o <= {31'h00000000, st_q != FRW_H_IDLE};
				`FRW_REG_RXDATA: rdata_o <= {24'h000000, rx_q};
				default: rdata_o <= 32'h00000000;
			endcase
		end else begin
			rdata_o <= 32'h00000000;
		end
	end

	// Link clock comes from a divider; a frame may stop mid-byte by design
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_q <= FRW_H_IDLE;
			cnt_q <= 8'h00;
			shift_q <= 40'h0000000000;
			bits_left_q <= 6'h00;
			rx_q <= 8'h00;
			cs_n_q <= 1'b1;
			sclk_q <= 1'b0;
			mosi_q <= 1'b0;
		end else begin
			if (!phase_end) begin
				cnt_q <= cnt_q - 8'h01;
			end
			case (st_q)
				FRW_H_IDLE: begin
					if (start) begin
						shift_q <= {wdata_i[7:0], tx_q};
						bits_left_q <= wdata_i[13:8];
						cs_n_q <= 1'b0;
						cnt_q <= 8'(`FRW_SCK_HALF_CYC - 1);
						st_q <= FRW_H_LEAD;
					end
				end
				FRW_H_LEAD, FRW_H_HIGH: begin
					if (phase_end) begin
						sclk_q <= 1'b0;
						cnt_q <= 8'(`FRW_SCK_HALF_CYC - 1);
						if (bits_left_q == 6'h00) begin
							st_q <= FRW_H_TRAIL;
						end else begin
							mosi_q <= shift_q[39];
							shift_q <= {shift_q[38:0], 1'b0};
							st_q <= FRW_H_LOW;
						end
					end
				end
				FRW_H_LOW: begin
					if (phase_end) begin
						sclk_q <= 1'b1;
						rx_q <= {rx_q[6:0], miso_s_q[1]};
						bits_left_q <= bits_left_q - 6'h01;
						cnt_q <= 8'(`FRW_SCK_HALF_CYC - 1);
						st_q <= FRW_H_HIGH;
					end
				end
				FRW_H_TRAIL: begin
					if (phase_end) begin
						cs_n_q <= 1'b1;
						cnt_q <= 8'(`FRW_CS_GAP_CYC - 1);
						st_q <= FRW_H_GAP;
					end
				end
				FRW_H_GAP: begin
					// Lets the far end see the release before the next frame
					if (phase_end) begin
						st_q <= FRW_H_IDLE;
					end
				end
				default: st_q <= FRW_H_IDLE;
			endcase
		end
	end

	assign lnk.cs_n = cs_n_q;
	assign lnk.sclk = sclk_q;
	assign lnk.mosi = mosi_q;

endmodule

// File: frw_link_properties.sv
// Checker for the flash command link and the device flags.
// Assumes the testbench instantiates it beside the interface, no bind.
module frw_link_properties (
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic miso,
	input wire logic busy_o,
	input wire logic suspended_o,
	input wire logic write_enable_latch_o,
	input wire logic [5:0] prot_bits_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Cycles since chip select went high; latch and busy may only rise, and halt and protection flags only change, shortly after
	logic [3:0] since_q;
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			since_q <= 4'hF;
		end else if (!cs_n) begin
			since_q <= 4'h0;
		end else if (since_q != 4'hF) begin
			since_q <= since_q + 4'h1;
		end
	end
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	a_sclk_idle_low: assert property (cs_n |-> !sclk) else $error("link clock high outside frame");
	a_mosi_held_high: assert property (sclk && $past(sclk) |-> $stable(mosi))
		else $error("data moved while link clock high");
	a_sclk_high_len: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
		else $error("link clock high phase wrong");
	a_sclk_low_len: assert property ($fell(sclk) && !cs_n |-> !sclk [*4])
		else $error("link clock low phase wrong");
	a_cs_gap_held: assert property ($rose(cs_n) |-> cs_n [*8]) else $error("frame gap too short");
	a_latch_set_cs: assert property ($rose(write_enable_latch_o) |-> since_q >= 4'h2 && since_q <= 4'h9)
		else $error("latch set away from frame end");
	a_busy_start_cs: assert property ($rose(busy_o) |-> since_q >= 4'h2 && since_q <= 4'h9)
		else $error("busy rose away from frame end");
	a_halt_flag_cs: assert property ($changed(suspended_o) |-> since_q >= 4'h2 && since_q <= 4'h9)
		else $error("halted flag moved away from frame end");
	a_prot_upd_cs: assert property ($changed(prot_bits_o) |-> since_q >= 4'h2 && since_q <= 4'h9)
		else $error("protection bits moved away from frame end");
	c_latch_set: cover property ($rose(write_enable_latch_o));
	c_resumed: cover property ($fell(suspended_o));
	c_prot_new: cover property ($changed(prot_bits_o));
endmodule

// File: tb.sv
// Testbench joining the host and device ends over one link.
// Assumes the host register map at 00h to 0Ch and an 800 ns link clock.
`include "frw_defs.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic wp_n_i = 1'b1;
	logic we_i = 1'b0;
	logic re_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic [31:0] rdata_o;
	logic busy_o;
	logic suspended_o;
	logic write_enable_latch_o;
	logic [5:0] prot_bits_o;
	int bad_count = 0;
	int cmp_count = 0;
	int nclk = 0;
	frw_if lnk();
	frw_device u_frw_device (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .lnk(lnk), .wp_n_i(wp_n_i),
		.busy_o(busy_o), .suspended_o(suspended_o), .write_enable_latch_o(write_enable_latch_o),
		.prot_bits_o(prot_bits_o));
	frw_host u_frw_host (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .lnk(lnk), .addr_i(addr_i),
		.wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o));
	frw_link_properties u_frw_link_properties (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
		.cs_n(lnk.cs_n), .sclk(lnk.sclk), .mosi(lnk.mosi), .miso(lnk.miso), .busy_o(busy_o),
		.suspended_o(suspended_o), .write_enable_latch_o(write_enable_latch_o), .prot_bits_o(prot_bits_o));
	always #50 mclk_i = ~mclk_i;
	// Link clock rises per frame, to count partial bytes at the pins
	always @(posedge lnk.sclk) nclk++;
	always @(negedge lnk.cs_n) nclk = 0;
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= d;
		we_i <= 1'b1;
		@(posedge mclk_i);
		we_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		re_i <= 1'b1;
		@(posedge mclk_i);
		re_i <= 1'b0;
		@(negedge mclk_i);
		d = rdata_o;
	endtask
	// Send one frame and poll the host until it is idle again
	task automatic frame(input logic [7:0] op, input logic [5:0] n, input logic [31:0] tx);
		logic [31:0] s;
		wr(`FRW_REG_TXDATA, tx);
		wr(`FRW_REG_CTRL, {18'h0, n, op});
		for (int i = 0; i < 1000; i++) begin
			rd(`FRW_REG_STATUS, s);
			if (s[0] === 1'b0) return;
		end
		chk("host status", s, 32'h0);
		summarize();
	endtask
	task automatic idle();
		for (int i = 0; i < 600; i++) begin
			@(negedge mclk_i);
			if (busy_o === 1'b0) return;
		end
		chk("busy_o", 32'(busy_o), 32'h0);
		summarize();
	endtask
	task automatic pcase(input logic [5:0] p, input logic [23:0] a, input logic r);
		frame(`FRW_OP_WR_EN, 6'h08, 32'h0);
		frame(`FRW_OP_WR_STAT, 6'h10, {2'b00, p, 24'h0});
		chk("prot_bits_o", 32'(prot_bits_o), 32'(p));
		frame(`FRW_OP_WR_EN, 6'h08, 32'h0);
		frame(`FRW_OP_PROGRAM, 6'h28, {a, 8'hA5});
		chk("busy_o", 32'(busy_o), 32'(r));
		idle();
		chk("write_enable_latch_o", 32'(write_enable_latch_o), 32'(!r));
	endtask
	task automatic t_wel();
		frame(`FRW_OP_WR_EN, 6'h08, 32'h0);
		chk("write_enable_latch_o", 32'(write_enable_latch_o), 32'h1);
		frame(`FRW_OP_WR_DIS, 6'h0C, 32'h0);
		chk("sclk count", nclk, 32'd12);
		chk("write_enable_latch_o", 32'(write_enable_latch_o), 32'h1);
		frame(`FRW_OP_WR_DIS, 6'h10, 32'hFF00_0000);
		chk("write_enable_latch_o", 32'(write_enable_latch_o), 32'h0);
		frame(`FRW_OP_WR_EN, 6'h0C, 32'h0);
		chk("write_enable_latch_o", 32'(write_enable_latch_o), 32'h0);
		frame(`FRW_OP_PROGRAM, 6'h28, 32'h0);
		chk("busy_o", 32'(busy_o), 32'h0);
		frame(`FRW_OP_WR_STAT, 6'h10, 32'h3F00_0000);
		chk("prot_bits_o", 32'(prot_bits_o), 32'h0);
		frame(`FRW_OP_WR_EN, 6'h10, 32'h5A00_0000);
		chk("write_enable_latch_o", 32'(write_enable_latch_o), 32'h1);
		$display("test latch done");
	endtask
	task automatic t_prot();
		@(posedge mclk_i);
		wp_n_i <= 1'b0;
		frame(`FRW_OP_WR_STAT, 6'h10, 32'h2A00_0000);
		chk("prot_bits_o", 32'(prot_bits_o), 32'h0);
		chk("write_enable_latch_o", 32'(write_enable_latch_o), 32'h1);
		@(posedge mclk_i);
		wp_n_i <= 1'b1;
		pcase(6'h01, 24'h1F0000, 1'b0);
		pcase(6'h01, 24'h1EFFFF, 1'b1);
		pcase(6'h09, 24'h00FFFF, 1'b0);
		pcase(6'h09, 24'h010000, 1'b1);
		pcase(6'h05, 24'h100000, 1'b0);
		pcase(6'h05, 24'h0FFFFF, 1'b1);
		pcase(6'h00, 24'h000000, 1'b1);
		pcase(6'h1E, 24'h000000, 1'b0);
		pcase(6'h11, 24'h1FF000, 1'b0);
		pcase(6'h11, 24'h1FEFFF, 1'b1);
		pcase(6'h1C, 24'h007FFF, 1'b0);
		pcase(6'h1C, 24'h008000, 1'b1);
		pcase(6'h20, 24'h1FFFFF, 1'b0);
		pcase(6'h26, 24'h000000, 1'b1);
		pcase(6'h21, 24'h1F0000, 1'b1);
		pcase(6'h21, 24'h1EFFFF, 1'b0);
		$display("test protection done");
	endtask
	task automatic t_res();
		logic [31:0] s;
		// Latch still set by the last refused program
		frame(`FRW_OP_ERASE, 6'h20, 32'h1F00_0000);
		chk("busy_o", 32'(busy_o), 32'h1);
		frame(`FRW_OP_HALT, 6'h08, 32'h0);
		chk("suspended_o", 32'(suspended_o), 32'h1);
		chk("busy_o", 32'(busy_o), 32'h0);
		frame(`FRW_OP_WR_DIS, 6'h08, 32'h0);
		frame(`FRW_OP_RD_STAT, 6'h10, 32'h0);
		rd(`FRW_REG_RXDATA, s);
		chk("status byte", {24'h0, s[7:0]}, 32'h04);
		frame(`FRW_OP_RESUME, 6'h0C, 32'h0);
		chk("suspended_o", 32'(suspended_o), 32'h1);
		frame(`FRW_OP_RESUME, 6'h10, 32'h7500_0000);
		chk("suspended_o", 32'(suspended_o), 32'h0);
		chk("busy_o", 32'(busy_o), 32'h1);
		// The restart latency has run out before this frame ends, so a second halt is legal here
		frame(`FRW_OP_HALT, 6'h08, 32'h0);
		chk("suspended_o", 32'(suspended_o), 32'h1);
		chk("busy_o", 32'(busy_o), 32'h0);
		frame(`FRW_OP_RESUME, 6'h08, 32'h0);
		chk("busy_o", 32'(busy_o), 32'h1);
		idle();
		frame(`FRW_OP_RESUME, 6'h08, 32'h0);
		chk("busy_o", 32'(busy_o), 32'h0);
		chk("suspended_o", 32'(suspended_o), 32'h0);
		$display("test resume done");
	endtask
	initial begin
		repeat (10) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		t_wel();
		t_prot();
		t_res();
		summarize();
	end
endmodule
